// ===== pkg/rst_lock_regs.svh
// Register offsets, field positions, reset values and timing counts of the reset and lock block
`ifndef RST_LOCK_REGS_SVH
`define RST_LOCK_REGS_SVH
`define RL_OFF_KEY 4'h0
`define RL_OFF_LOCK0 4'h1
`define RL_OFF_RSTSRC 4'h2
`define RL_OFF_RSTMOD 4'h3
`define RL_OFF_DBGRUN 4'h4
`define RL_OFF_STATUS 4'h5
`define RL_OFF_SCRATCH 4'h6
`define RL_LOCK0_CLKRST_BIT 0
`define RL_LOCK0_RESET 32'h0000_0000
`define RL_RSTSRC_RESET 32'h0000_0000
`define RL_RSTMOD_RESET 5'h00
`define RL_DBGRUN_RESET 32'h0000_0000
`define RL_KEY_LEN 2
`define RL_KEY0 8'ha5
`define RL_KEY1 8'hf1
`define RL_RESET_VECTOR 32'h0000_0000
`define RL_CLKSEL_LPOSC 2'h0
`define RL_NUM_PERIPH 32
`define RL_APB_ALWAYS_ON 32'h0000_0003
`define RL_RELEASE_CYCLES 4'h3
`endif

// ===== pkg/rst_lock_pkg.sv
// Types for the reset and lock block
`default_nettype none
package rst_lock_pkg;
  typedef enum logic [1:0] {
    key_locked,
    key_partial,
    key_unlocked
  } key_state_type;
  typedef enum logic [1:0] {
    rst_active,
    rst_release,
    rst_run
  } rst_state_type;
  typedef struct packed {
    logic cpu_halt;
    logic [31:0] pc_init;
    logic [1:0] clk_sel;
    logic wdt_run;
    logic wdt_lfo;
    logic irq_off;
    logic timer_off;
    logic ahb_mem_clk_on;
  } core_ctrl_type;
  typedef struct packed {
    logic [15:0] latch_high;
    logic [15:0] open_drain;
    logic [15:0] weak_pullup;
  } port_safe_type;
endpackage
`default_nettype wire

// ===== src/rst_lock.sv
// Reset sequencer with peripheral key-and-lock write protection
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "rst_lock_regs.svh"

// Operation
// [RQ1] Core is halted for as long as the reset state lasts
// [RQ2] Registers return to reset values; power-on-only fields keep theirs
// [RQ3] Port latches sit at one in open-drain mode during reset
// [RQ4] Weak pull-ups on during reset and left on afterward
// [RQ5] Reset disables all interrupts and timers
// [RQ6] Flash and RAM bus clocks are on during reset
// [RQ7] Peripheral clocks gated in reset except watchdog and DMA crossbar
// [RQ8] Reset never touches RAM contents
// [RQ9] Power-on or supply monitor reset drives reset pin low until exit
// [RQ10] On exit program counter cleared and low-power oscillator selected
// [RQ11] On exit watchdog runs from the low-frequency oscillator
// [RQ12] First fetch after release is from address zero
// [RQ13] Setting clock/reset lock bit blocks writes to reset-source registers
// [RQ14] Reset sources may also reset five selected modules
// [RQ15] Each lock word bit protects one peripheral group
// [RQ16] Lock words change only after the correct key sequence
// [RQ17] Any key write after unlocking locks the lock words again
// [RQ18] Key register read reports lock state
// [RQ19] Writes to locked peripherals are discarded
// [RQ20] Locked peripherals still read normally
// [RQ21] Per-module choice to freeze or run during debug halt
// [RQ22] Key values and length are parameters; wrong write restarts sequence (keys are defines here; the sequence is fixed at two steps, RL_KEY_LEN unused)
// [RQ23] Reset held until all sources drop, then released synchronously
module rst_lock (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_supply_mon,
  input wire logic [7:0] i_other_rst_src,
  input wire logic i_dbg_halt,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] i_periph_wr_sel,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_in_reset,
  output logic o_rst_pin_out,
  output logic o_rst_pin_oe,
  output var rst_lock_pkg::core_ctrl_type o_core,
  output var rst_lock_pkg::port_safe_type o_port,
  output logic [31:0] o_apb_clk_en,
  output logic [31:0] o_periph_wr_allow,
  output logic [31:0] o_periph_freeze,
  output logic [4:0] o_module_rst
);
  rst_lock_pkg::rst_state_type rst_state_q;
  rst_lock_pkg::key_state_type key_state_q;
  logic [3:0] rel_cnt_q;
  logic hard_src_q;
  logic [31:0] lock0_q;
  logic [31:0] rstsrc_q;
  logic [4:0] rstmod_q;
  logic [31:0] dbgrun_q;
  logic [31:0] scratch_q;
  logic ack_q;
  logic any_src;
  logic wr_stb;
  logic rd_stb;
  logic in_rst;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  assign any_src = i_por | i_supply_mon | (|i_other_rst_src);
  assign in_rst = (rst_state_q != rst_lock_pkg::rst_run);
  // One wait state per access; a write lands at the edge that sees waitrequest low,
  // so nothing changes before the master has been told its transfer is done
  assign wr_stb = i_avs_write & ack_q & ~in_rst;
  assign rd_stb = i_avs_read & ~ack_q;

  // Reset sequencer
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rst_state_q <= rst_lock_pkg::rst_active;
      rel_cnt_q <= 4'h0;
    end else if (any_src) begin
      rst_state_q <= rst_lock_pkg::rst_active; // RQ23
      rel_cnt_q <= 4'h0;
    end else begin
      case (rst_state_q)
        rst_lock_pkg::rst_active: begin
          rst_state_q <= rst_lock_pkg::rst_release;
          rel_cnt_q <= 4'h0;
        end
        rst_lock_pkg::rst_release: begin
          // Short settle count so a glitching source cannot release the core at once
          rel_cnt_q <= rel_cnt_q + 4'h1;
          if (rel_cnt_q == `RL_RELEASE_CYCLES - 4'h1) begin
            rst_state_q <= rst_lock_pkg::rst_run; // RQ23
          end
        end
        rst_lock_pkg::rst_run: rst_state_q <= rst_lock_pkg::rst_run;
        default: rst_state_q <= rst_lock_pkg::rst_active;
      endcase
    end
  end

  // Remember a power-on or supply-monitor cause until reset exit
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hard_src_q <= 1'b1;
    end else if (i_por | i_supply_mon) begin
      hard_src_q <= 1'b1;
    end else if (rst_state_q == rst_lock_pkg::rst_run) begin
      hard_src_q <= 1'b0;
    end
  end

  // Reset pin and core control outputs
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_in_reset <= 1'b1;
      o_rst_pin_out <= 1'b0;
      o_rst_pin_oe <= 1'b1;
      o_core <= '{cpu_halt: 1'b1, pc_init: `RL_RESET_VECTOR, clk_sel: `RL_CLKSEL_LPOSC,
                  wdt_run: 1'b0, wdt_lfo: 1'b1, irq_off: 1'b1, timer_off: 1'b1,
                  ahb_mem_clk_on: 1'b1};
      o_apb_clk_en <= `RL_APB_ALWAYS_ON;
    end else begin
      o_in_reset <= in_rst;
      o_rst_pin_out <= 1'b0;
      o_rst_pin_oe <= in_rst & hard_src_q; // RQ9
      o_core.cpu_halt <= in_rst; // RQ1
      o_core.irq_off <= in_rst; // RQ5
      o_core.timer_off <= in_rst; // RQ5
      o_core.ahb_mem_clk_on <= 1'b1; // RQ6
      o_core.wdt_lfo <= 1'b1; // RQ11
      o_core.wdt_run <= ~in_rst; // RQ11
      if (in_rst) begin
        o_core.pc_init <= `RL_RESET_VECTOR; // RQ10 RQ12
        o_core.clk_sel <= `RL_CLKSEL_LPOSC; // RQ10
        o_apb_clk_en <= `RL_APB_ALWAYS_ON; // RQ7
      end else begin
        o_apb_clk_en <= 32'hffff_ffff;
      end
    end
  end

  // Safe pin state; pull-ups stay on after release, latches are left to the port block
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_port <= '{latch_high: 16'hffff, open_drain: 16'hffff, weak_pullup: 16'hffff};
    end else begin
      o_port.weak_pullup <= 16'hffff; // RQ4
      o_port.latch_high <= in_rst ? 16'hffff : 16'h0000; // RQ3
      o_port.open_drain <= in_rst ? 16'hffff : 16'h0000; // RQ3
    end
  end

  // Module resets selected by the one reset-module register, the same for every source
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_module_rst <= 5'h1f;
    end else begin
      o_module_rst <= in_rst ? rstmod_q : 5'h00; // RQ14
    end
  end

  // Key sequence for the lock words
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      key_state_q <= rst_lock_pkg::key_locked;
    end else if (in_rst) begin
      key_state_q <= rst_lock_pkg::key_locked; // RQ2
    end else if (wr_stb && hit(i_avs_address, `RL_OFF_KEY)) begin
      case (key_state_q)
        rst_lock_pkg::key_locked:
          key_state_q <= (i_avs_writedata[7:0] == `RL_KEY0) ?
                         rst_lock_pkg::key_partial : rst_lock_pkg::key_locked; // RQ22
        rst_lock_pkg::key_partial:
          key_state_q <= (i_avs_writedata[7:0] == `RL_KEY1) ?
                         rst_lock_pkg::key_unlocked : rst_lock_pkg::key_locked; // RQ16 RQ22
        rst_lock_pkg::key_unlocked: key_state_q <= rst_lock_pkg::key_locked; // RQ17
        default: key_state_q <= rst_lock_pkg::key_locked;
      endcase
    end
  end

  // Lock words; these fields clear on every reset entry
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lock0_q <= `RL_LOCK0_RESET;
    end else if (in_rst) begin
      lock0_q <= `RL_LOCK0_RESET; // RQ2
    end else if (wr_stb && hit(i_avs_address, `RL_OFF_LOCK0)
                 && key_state_q == rst_lock_pkg::key_unlocked) begin
      lock0_q <= i_avs_writedata; // RQ16
    end
  end

  // Reset-source registers, guarded by the clock/reset lock bit
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rstsrc_q <= `RL_RSTSRC_RESET;
      rstmod_q <= `RL_RSTMOD_RESET;
    end else if (!lock0_q[`RL_LOCK0_CLKRST_BIT] && wr_stb) begin // RQ13
      if (hit(i_avs_address, `RL_OFF_RSTSRC)) begin
        rstsrc_q <= i_avs_writedata;
      end
      if (hit(i_avs_address, `RL_OFF_RSTMOD)) begin
        rstmod_q <= i_avs_writedata[4:0]; // RQ14
      end
    end
  end

  // Debug run enables; cleared by reset entry as ordinary fields
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dbgrun_q <= `RL_DBGRUN_RESET;
    end else if (in_rst) begin
      dbgrun_q <= `RL_DBGRUN_RESET; // RQ2
    end else if (wr_stb && hit(i_avs_address, `RL_OFF_DBGRUN)) begin
      dbgrun_q <= i_avs_writedata;
    end
  end

  // Scratch word stands for RAM: only i_rst clears it, not i_por or any other reset source
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      scratch_q <= 32'h0000_0000;
    end else if (wr_stb && hit(i_avs_address, `RL_OFF_SCRATCH)) begin
      scratch_q <= i_avs_writedata; // RQ8
    end
  end

  // Peripheral write gating and debug freeze, one bit per group
  genvar g;
  generate
    for (g = 0; g < `RL_NUM_PERIPH; g++) begin : g_periph
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          o_periph_wr_allow[g] <= 1'b1;
          o_periph_freeze[g] <= 1'b0;
        end else begin
          o_periph_wr_allow[g] <= ~lock0_q[g]; // RQ15 RQ19
          o_periph_freeze[g] <= i_dbg_halt & ~dbgrun_q[g]; // RQ21
        end
      end
    end
  endgenerate

  // Avalon slave: readback unaffected by lock state, unmapped reads zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
      if (rd_stb) begin
        case (i_avs_address)
          `RL_OFF_KEY: o_avs_readdata <= {31'h0, key_state_q != rst_lock_pkg::key_unlocked}; // RQ18
          `RL_OFF_LOCK0: o_avs_readdata <= lock0_q; // RQ20
          `RL_OFF_RSTSRC: o_avs_readdata <= rstsrc_q;
          `RL_OFF_RSTMOD: o_avs_readdata <= {27'h0, rstmod_q};
          `RL_OFF_DBGRUN: o_avs_readdata <= dbgrun_q;
          `RL_OFF_STATUS: o_avs_readdata <= {30'h0, hard_src_q, in_rst};
          `RL_OFF_SCRATCH: o_avs_readdata <= scratch_q;
          default: o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack_q);
    end
  end

  // Guards on the reset state
  halt_in_reset_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ1
    in_rst |=> o_core.cpu_halt) else $error("core not halted in reset");
  pins_safe_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ3
    in_rst |=> (o_port.latch_high == 16'hffff && o_port.open_drain == 16'hffff))
    else $error("pins not safe in reset");
  pullup_kept_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ4
    ##1 o_port.weak_pullup == 16'hffff) else $error("pull-up dropped");
  irq_timer_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ5
    in_rst |=> (o_core.irq_off && o_core.timer_off)) else $error("interrupts or timers live");
  mem_clk_on_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ6
    in_rst |=> o_core.ahb_mem_clk_on) else $error("memory bus clock off in reset");
  apb_gated_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ7
    in_rst |=> o_apb_clk_en == `RL_APB_ALWAYS_ON) else $error("apb clocks open");
  rst_pin_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ9
    (i_por || i_supply_mon) |=> ##1 o_rst_pin_oe) else $error("reset pin not driven");
  pin_released_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ9
    !in_rst |=> !o_rst_pin_oe) else $error("reset pin driven after exit");
  exit_defaults_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ10 RQ12
    $fell(in_rst) |=> (!o_core.cpu_halt && o_core.pc_init == `RL_RESET_VECTOR
    && o_core.clk_sel == `RL_CLKSEL_LPOSC)) else $error("wrong state at reset exit");
  wdt_running_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ11
    !in_rst |=> (o_core.wdt_run && o_core.wdt_lfo)) else $error("watchdog not running");
  lock_cleared_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ2
    in_rst |=> lock0_q == `RL_LOCK0_RESET) else $error("lock word kept through reset");
  fields_kept_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ2 RQ8
    in_rst |=> ($stable(rstmod_q) && $stable(rstsrc_q) && $stable(scratch_q)))
    else $error("retained field changed in reset");
  module_rst_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ14
    in_rst |=> o_module_rst == rstmod_q) else $error("module resets not applied");
  release_sync_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ23
    ($fell(any_src)) |-> ##4 (rst_state_q == rst_lock_pkg::rst_run || any_src))
    else $error("release not timed");

  // Guards on the key, the lock words and the debug freeze
  lock_blocks_src_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ13
    (lock0_q[`RL_LOCK0_CLKRST_BIT] && !in_rst) |=> ($stable(rstsrc_q) && $stable(rstmod_q)))
    else $error("locked source register changed");
  key_relock_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ17
    (wr_stb && hit(i_avs_address, `RL_OFF_KEY) && key_state_q == rst_lock_pkg::key_unlocked)
    |=> key_state_q == rst_lock_pkg::key_locked) else $error("key did not relock");
  lock_needs_key_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ16
    (key_state_q != rst_lock_pkg::key_unlocked && !in_rst) |=> $stable(lock0_q))
    else $error("lock word changed while locked");
  key_status_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ18
    (rd_stb && hit(i_avs_address, `RL_OFF_KEY)) |=> o_avs_readdata[0]
    == $past(key_state_q != rst_lock_pkg::key_unlocked)) else $error("key status wrong");
  lock_readback_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ20
    (rd_stb && hit(i_avs_address, `RL_OFF_LOCK0)) |=> o_avs_readdata
    == $past(lock0_q)) else $error("lock word readback wrong");
  wr_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ15 RQ19
    1'b1 |=> o_periph_wr_allow == ~$past(lock0_q)) else $error("write gate off lock word");
  freeze_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RQ21
    1'b1 |=> o_periph_freeze == ({32{$past(i_dbg_halt)}} & ~$past(dbgrun_q)))
    else $error("debug freeze wrong");

  // Scenarios worth seeing in a run
  cov_unlock_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    key_state_q == rst_lock_pkg::key_unlocked);
  cov_lockset_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    lock0_q[`RL_LOCK0_CLKRST_BIT]);
  cov_release_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_core.wdt_run));
  cov_hard_pin_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_rst_pin_oe && !i_por);
  cov_freeze_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    |o_periph_freeze);
endmodule // rst_lock
`default_nettype wire

// ===== sim/test_reset_state_and_peripheral_lock.sv
// Self-checking bench for the reset sequencer and peripheral lock block
`timescale 1ns/1ns
`default_nettype none
`include "rst_lock_regs.svh"
module test_reset_state_and_peripheral_lock;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_por = 1'b1;
  logic i_supply_mon = 1'b0;
  logic [7:0] i_other_rst_src = 8'h00;
  logic i_dbg_halt = 1'b0;
  logic [3:0] i_avs_address = 4'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_in_reset, o_rst_pin_out, o_rst_pin_oe;
  rst_lock_pkg::core_ctrl_type o_core;
  rst_lock_pkg::port_safe_type o_port;
  logic [31:0] o_apb_clk_en, o_periph_wr_allow, o_periph_freeze;
  logic [4:0] o_module_rst;
  logic [31:0] q;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  rst_lock DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_por(i_por),
    .i_supply_mon(i_supply_mon), .i_other_rst_src(i_other_rst_src), .i_dbg_halt(i_dbg_halt),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_periph_wr_sel(32'h0000_0000),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_in_reset(o_in_reset), .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe),
    .o_core(o_core), .o_port(o_port), .o_apb_clk_en(o_apb_clk_en),
    .o_periph_wr_allow(o_periph_wr_allow), .o_periph_freeze(o_periph_freeze),
    .o_module_rst(o_module_rst));

  always #2 i_clk_sys = ~i_clk_sys;

  task automatic end_of_test();
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares = miscompares + 1;
    end
  endtask

  // Entered just after a rising edge; holds the request until waitrequest is sampled low
  // Only the bench timeout ends a wait that never completes
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    i_avs_address <= a;
    i_avs_writedata <= d;
    if (wr) i_avs_write <= 1'b1;
    else i_avs_read <= 1'b1;
    @(posedge i_clk_sys);
    while (o_avs_waitrequest !== 1'b0) begin
      @(posedge i_clk_sys);
    end
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic unlock();
    bus(1'b1, `RL_OFF_KEY, {24'h0, `RL_KEY0});
    bus(1'b1, `RL_OFF_KEY, {24'h0, `RL_KEY1});
  endtask

  task automatic wait_exit();
    int n;
    n = 0;
    while (o_in_reset !== 1'b0 && n < 40) begin
      @(posedge i_clk_sys);
      n = n + 1;
    end
    chk(48'(o_in_reset), 48'h0);
  endtask

  task automatic t_power_on();
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk(48'({o_in_reset, o_core.cpu_halt}), 48'h3);
    chk(o_port, 48'hffff_ffff_ffff);
    chk(48'({o_core.irq_off, o_core.timer_off}), 48'h3);
    chk(48'(o_core.ahb_mem_clk_on), 48'h1);
    chk(48'(o_apb_clk_en), 48'(`RL_APB_ALWAYS_ON));
    chk(48'({o_rst_pin_oe, o_rst_pin_out}), 48'h2);
    i_por <= 1'b0;
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    chk(48'(o_in_reset), 48'h1);
    wait_exit();
    chk(48'({o_core.cpu_halt, o_rst_pin_oe}), 48'h0);
    chk(48'(o_core.pc_init), 48'(`RL_RESET_VECTOR));
    chk(48'(o_core.clk_sel), 48'(`RL_CLKSEL_LPOSC));
    chk(48'({o_core.wdt_run, o_core.wdt_lfo}), 48'h3);
    chk(48'(o_port.weak_pullup), 48'hffff);
    chk(48'(o_apb_clk_en), 48'hffff_ffff);
  endtask

  task automatic t_debug();
    bus(1'b1, `RL_OFF_DBGRUN, 32'h0000_00f0);
    i_dbg_halt <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk(48'(o_periph_freeze), 48'hffff_ff0f);
    i_dbg_halt <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    chk(48'(o_periph_freeze), 48'h0);
  endtask

  task automatic t_key_lock();
    bus(1'b0, `RL_OFF_KEY, 32'h0);
    chk(48'(q[0]), 48'h1);
    bus(1'b1, `RL_OFF_LOCK0, 32'h0000_0006);
    bus(1'b0, `RL_OFF_LOCK0, 32'h0);
    chk(48'(q), 48'h0);
    bus(1'b1, `RL_OFF_KEY, {24'h0, `RL_KEY0});
    bus(1'b1, `RL_OFF_KEY, 32'h0000_0000);
    bus(1'b1, `RL_OFF_KEY, {24'h0, `RL_KEY1});
    bus(1'b0, `RL_OFF_KEY, 32'h0);
    chk(48'(q[0]), 48'h1);
    unlock();
    bus(1'b0, `RL_OFF_KEY, 32'h0);
    chk(48'(q[0]), 48'h0);
    bus(1'b1, `RL_OFF_LOCK0, 32'h0000_0006);
    bus(1'b1, `RL_OFF_KEY, 32'h0000_0000);
    bus(1'b0, `RL_OFF_KEY, 32'h0);
    chk(48'(q[0]), 48'h1);
    bus(1'b1, `RL_OFF_LOCK0, 32'h0000_0000);
    bus(1'b0, `RL_OFF_LOCK0, 32'h0);
    chk(48'(q), 48'h6);
    chk(48'(o_periph_wr_allow), 48'hffff_fff9);
  endtask

  task automatic t_source_lock();
    bus(1'b1, `RL_OFF_RSTMOD, 32'h0000_0015);
    bus(1'b1, `RL_OFF_SCRATCH, 32'h1234_abcd);
    unlock();
    bus(1'b1, `RL_OFF_LOCK0, 32'h0000_0001);
    bus(1'b1, `RL_OFF_KEY, 32'h0000_0000);
    bus(1'b1, `RL_OFF_RSTMOD, 32'h0000_000a);
    bus(1'b0, `RL_OFF_RSTMOD, 32'h0);
    chk(48'(q[4:0]), 48'h15);
    chk(48'(o_periph_wr_allow), 48'hffff_fffe);
    i_other_rst_src <= 8'h08;
    repeat (3) @(posedge i_clk_sys);
    chk(48'({o_in_reset, o_core.cpu_halt}), 48'h3);
    chk(48'(o_module_rst), 48'h15);
    i_other_rst_src <= 8'h00;
    @(posedge i_clk_sys);
    wait_exit();
    chk(48'(o_module_rst), 48'h0);
    bus(1'b0, `RL_OFF_RSTMOD, 32'h0);
    chk(48'(q[4:0]), 48'h15);
    bus(1'b0, `RL_OFF_SCRATCH, 32'h0);
    chk(48'(q), 48'h1234_abcd);
    bus(1'b0, `RL_OFF_LOCK0, 32'h0);
    chk(48'(q), 48'(`RL_LOCK0_RESET));
  endtask

  task automatic t_supply();
    i_supply_mon <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk(48'({o_in_reset, o_rst_pin_oe}), 48'h3);
    i_supply_mon <= 1'b0;
    @(posedge i_clk_sys);
    wait_exit();
    chk(48'(o_rst_pin_oe), 48'h0);
  endtask

  initial begin
    t_power_on();
    t_debug();
    t_key_lock();
    t_source_lock();
    t_supply();
    end_of_test();
  end
endmodule // test_reset_state_and_peripheral_lock
`default_nettype wire
